// >>> hdl/pwmrpd_regs.svh
// Purpose: register offsets, field positions and reset values
// Assumes: register port carries 12-bit addresses
// Notes:   definitions only
`ifndef PWMRPD_REGS_SVH
`define PWMRPD_REGS_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define PWMRPD_OFS_CONTROL_ZERO 12'hF20
`define PWMRPD_OFS_CONTROL_ONE  12'hF21
`define PWMRPD_OFS_DEAD_TIME    12'hF22
// ----------------------------------------
// field positions
// ----------------------------------------
`define PWMRPD_RLF_HI   7
`define PWMRPD_RLF_LO   6
`define PWMRPD_INDEP    5
`define PWMRPD_POL_PAIR45 4
`define PWMRPD_POL_PAIR23 3
`define PWMRPD_POL_PAIR10 2
`define PWMRPD_DIV_HI   1
`define PWMRPD_DIV_LO   0
`define PWMRPD_READY    1
`define PWMRPD_ENABLE   0
// ----------------------------------------
// reset values
// ----------------------------------------
`define PWMRPD_CTL0_RST 8'h00
`define PWMRPD_CTL1_RST 8'h00
`define PWMRPD_DB_RST   8'h01
`endif

// >>> hdl/pwmrpd_pkg.sv
// Purpose: shared types of the pwm reload, prescale and deadband block
// Assumes: nothing
// Notes:   offsets, field positions and reset values live in pwmrpd_regs.svh
package pwmrpd_pkg;
   // dead-time sequencer of one complementary pair, gray along the path
   typedef enum logic [1:0] {
      PWMRPD_IDLE = 2'b00,
      PWMRPD_DEAD = 2'b01,
      PWMRPD_LIVE = 2'b11
   } pwmrpd_dt_state_type;
endpackage : pwmrpd_pkg

// >>> hdl/pwmrpd_dt_if.sv
// Purpose: carries one pair's raw request and shaped outputs
// Assumes: single clock domain
// Notes:   used between top and dead-time pair module
`timescale 1ns/1ps
`default_nettype none
interface pwmrpd_dt_if;
   logic       raw_high;   // requested state: high side active
   logic       complement; // pair in complementary mode
   logic [7:0] dead_count; // dead time in clock cycles
   logic       out_high;
   logic       out_low;
   modport ctl (output raw_high, output complement, output dead_count,
                input out_high, input out_low);
   modport pair (input raw_high, input complement, input dead_count,
                 output out_high, output out_low);
endinterface : pwmrpd_dt_if
`default_nettype wire

// >>> hdl/pwmrpd_dead_pair.sv
// Purpose: dead-time insertion for one output pair
// Assumes: dead_count is at least one
// Notes:   in independent mode the raw request passes straight through
`timescale 1ns/1ps
`default_nettype none
module pwmrpd_dead_pair (
   input  wire logic clock,
   input  wire logic rst_b,
   input  wire logic raw_low,
   pwmrpd_dt_if.pair dt
);
   pwmrpd_pkg::pwmrpd_dt_state_type state_r, state_nxt;
   logic [7:0] cnt_r, cnt_nxt;
   logic       side_r, side_nxt;  // side currently granted (1 = high)
   logic       oh_r, oh_nxt, ol_r, ol_nxt;

   // ----------------------------------------
   // next state
   // ----------------------------------------
   // both sides forced off while counting; new side only after the count
   always_comb begin
      state_nxt = state_r;
      cnt_nxt   = cnt_r;
      side_nxt  = side_r;
      oh_nxt    = oh_r;
      ol_nxt    = ol_r;
      if (!dt.complement) begin
         state_nxt = pwmrpd_pkg::PWMRPD_IDLE;
         oh_nxt    = dt.raw_high;
         ol_nxt    = raw_low;
      end else begin
         case (state_r)
            pwmrpd_pkg::PWMRPD_IDLE: begin
               oh_nxt    = 1'b0;
               ol_nxt    = 1'b0;
               side_nxt  = dt.raw_high;
               cnt_nxt   = dt.dead_count;
               state_nxt = pwmrpd_pkg::PWMRPD_DEAD;
            end
            pwmrpd_pkg::PWMRPD_DEAD: begin
               oh_nxt = 1'b0;
               ol_nxt = 1'b0;
               if (dt.raw_high != side_r) begin
                  side_nxt = dt.raw_high;
                  cnt_nxt  = dt.dead_count;
               end else if (cnt_r <= 8'h01) begin
                  state_nxt = pwmrpd_pkg::PWMRPD_LIVE;
                  oh_nxt    = side_r;
                  ol_nxt    = !side_r;
               end else begin
                  cnt_nxt = cnt_r - 8'h01;
               end
            end
            pwmrpd_pkg::PWMRPD_LIVE: begin
               if (dt.raw_high != side_r) begin
                  oh_nxt    = 1'b0;
                  ol_nxt    = 1'b0;
                  side_nxt  = dt.raw_high;
                  cnt_nxt   = dt.dead_count;
                  state_nxt = pwmrpd_pkg::PWMRPD_DEAD;
               end
            end
            default: state_nxt = pwmrpd_pkg::PWMRPD_IDLE;
         endcase
      end
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         state_r <= pwmrpd_pkg::PWMRPD_IDLE;
         cnt_r   <= 8'h00;
         side_r  <= 1'b0;
         oh_r    <= 1'b0;
         ol_r    <= 1'b0;
      end else begin
         state_r <= state_nxt;
         cnt_r   <= cnt_nxt;
         side_r  <= side_nxt;
         oh_r    <= oh_nxt;
         ol_r    <= ol_nxt;
      end
   end

   assign dt.out_high = oh_r;
   assign dt.out_low  = ol_r;
endmodule : pwmrpd_dead_pair
`default_nettype wire

// >>> hdl/pwmrpd_top.sv
// Purpose: reload timing, prescaler, polarity and dead time of a six-output pwm
// Assumes: period_end pulses and raw channel requests come from the counter logic
// Notes:   duty and period compare live outside; this block shapes and times them
`timescale 1ns/1ps
`default_nettype none
`include "pwmrpd_regs.svh"

module pwmrpd_top #(
   parameter int CHANNELS = 6
) (
   input  wire logic                clock,
   input  wire logic                rst_b,
   input  wire logic [11:0]         addr,
   input  wire logic [7:0]          wdata,
   input  wire logic                wr_stb,
   input  wire logic                rd_stb,
   output var  logic [7:0]          rdata,
   input  wire logic                ext_clock_select,
   input  wire logic                ext_pwm_clock,
   input  wire logic                period_end,
   input  wire logic [CHANNELS-1:0] raw_channel,
   output var  logic                pwm_tick,
   output var  logic                reload_event,
   output var  logic [1:0]          active_divider,
   output var  logic                unit_enable,
   output var  logic [CHANNELS-1:0] pwm_out
);
   localparam int PAIRS = CHANNELS / 2;

   // ----------------------------------------
   // overview
   // ----------------------------------------
   // the duty compare that makes raw_channel sits outside; raw_channel is a
   // clean level and period_end a one-cycle pulse, since a level held high
   // would count as one finished period on every clock it stays high.
   // dead time counts system clocks, not prescaled ticks, so it stays fixed
   // while the divider changes; after reset each pair starts in dead time, so
   // no gate turns on before one full dead count has run.

   // ----------------------------------------
   // register state
   // ----------------------------------------
   // control one is kept only as its holding copy; the fields that must not
   // move in the middle of a period are mirrored into the _act registers
   logic [7:0] ctl0_r, ctl0_nxt;
   logic [7:0] ctl1_r, ctl1_nxt;          // holding copy of control one
   logic [7:0] db_r, db_nxt;
   logic [1:0] rlf_act_r, rlf_act_nxt;    // reload frequency in effect
   logic [1:0] div_act_r, div_act_nxt;    // divider in effect
   logic [7:0] rdata_nxt;
   logic       wr_ctl0, wr_ctl1, wr_db;

   // strobes decode the full 12-bit offset, so neighbouring registers of
   // the unit never alias onto these three; unmapped writes simply vanish
   // and leave every holding copy as it was
   assign wr_ctl0 = wr_stb && (addr == `PWMRPD_OFS_CONTROL_ZERO);
   assign wr_ctl1 = wr_stb && (addr == `PWMRPD_OFS_CONTROL_ONE);
   assign wr_db   = wr_stb && (addr == `PWMRPD_OFS_DEAD_TIME);

   // ----------------------------------------
   // reload scheduling
   // ----------------------------------------
   // reload_r trails the closing period_end by one edge and reload_event by
   // two, so software sees the event two cycles after the period ends
   logic [2:0] per_cnt_r, per_cnt_nxt;
   logic       reload_r, reload_nxt;
   logic [2:0] per_last;

   // periods per reload minus one: 0, 1, 3, 7
   always_comb begin
      case (rlf_act_r)
         2'h0:    per_last = 3'h0;
         2'h1:    per_last = 3'h1;
         2'h2:    per_last = 3'h3;
         default: per_last = 3'h7;
      endcase
   end

   // count finished periods; fire reload on the last one of the group
   // the compare is >= so a smaller group taken mid-group closes at the
   // next period end instead of wrapping through all eight counts
   always_comb begin
      per_cnt_nxt = per_cnt_r;
      reload_nxt  = 1'b0;
      if (period_end) begin
         if (per_cnt_r >= per_last) begin
            per_cnt_nxt = 3'h0;
            reload_nxt  = 1'b1;
         end else begin
            per_cnt_nxt = per_cnt_r + 3'h1;
         end
      end
   end

   // ----------------------------------------
   // register file next values
   // ----------------------------------------
   always_comb begin
      ctl0_nxt    = ctl0_r;
      ctl1_nxt    = ctl1_r;
      db_nxt      = db_r;
      rlf_act_nxt = rlf_act_r;
      div_act_nxt = div_act_r;
      // divider moves only at a reload and only when software says ready;
      // it is taken with the internal reload strobe so the new code shows
      // on active_divider in the same cycle as reload_event
      if (reload_nxt && ctl0_r[`PWMRPD_READY]) begin
         div_act_nxt = ctl1_r[`PWMRPD_DIV_HI:`PWMRPD_DIV_LO];
         ctl0_nxt[`PWMRPD_READY] = 1'b0;
      end
      // a control zero write in the same cycle wins over the auto-clear, so
      // a ready flag raised for the following reload is never lost
      if (wr_ctl0) begin
         ctl0_nxt = {6'h00, wdata[`PWMRPD_READY], wdata[`PWMRPD_ENABLE]};
      end
      if (wr_ctl1) begin
         ctl1_nxt = wdata;
         // mode bit is frozen while running so the live pairing stays intact
         if (ctl0_r[`PWMRPD_ENABLE]) begin
            ctl1_nxt[`PWMRPD_INDEP] = ctl1_r[`PWMRPD_INDEP];
         end
      end
      // the freeze is a safety net, not a queue: a refused dead-time write
      // is dropped and never applied once the unit is disabled again
      if (wr_db && !ctl0_r[`PWMRPD_ENABLE]) begin
         db_nxt = wdata;
      end
      // reload frequency follows its holding copy at every period end
      if (period_end) begin
         rlf_act_nxt = ctl1_r[`PWMRPD_RLF_HI:`PWMRPD_RLF_LO];
      end
   end

   // ----------------------------------------
   // read data, valid the cycle after the strobe
   // ----------------------------------------
   // idle cycles return zero so several slaves can share an or-combined
   // read bus without extra gating; an unmapped offset also reads zero,
   // never stale data from an earlier access
   always_comb begin
      rdata_nxt = 8'h00;
      if (rd_stb) begin
         case (addr)
            `PWMRPD_OFS_CONTROL_ZERO: rdata_nxt = ctl0_r;
            `PWMRPD_OFS_CONTROL_ONE:  rdata_nxt = ctl1_r;
            `PWMRPD_OFS_DEAD_TIME:    rdata_nxt = db_r;
            default:                  rdata_nxt = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         ctl0_r    <= `PWMRPD_CTL0_RST;
         ctl1_r    <= `PWMRPD_CTL1_RST;
         db_r      <= `PWMRPD_DB_RST;
         rlf_act_r <= 2'h0;
         div_act_r <= 2'h0;
         per_cnt_r <= 3'h0;
         reload_r  <= 1'b0;
         rdata     <= 8'h00;
      end else begin
         ctl0_r    <= ctl0_nxt;
         ctl1_r    <= ctl1_nxt;
         db_r      <= db_nxt;
         rlf_act_r <= rlf_act_nxt;
         div_act_r <= div_act_nxt;
         per_cnt_r <= per_cnt_nxt;
         reload_r  <= reload_nxt;
         rdata     <= rdata_nxt;
      end
   end

   // ----------------------------------------
   // input clock select and prescaler
   // ----------------------------------------
   // the external input is sampled as a level; its rising edge is one source tick
   // limitation: each level must last at least one system clock, so the
   // external rate is capped at half the system clock; faster edges are lost
   logic ext_prev_r, ext_prev_nxt;
   logic src_tick;
   logic [2:0] pre_cnt_r, pre_cnt_nxt;
   logic [2:0] pre_last;
   logic       tick_nxt;

   assign ext_prev_nxt = ext_pwm_clock;
   assign src_tick     = ext_clock_select ? (ext_pwm_clock && !ext_prev_r)
                                          : 1'b1;

   always_comb begin
      case (div_act_r)
         2'h0:    pre_last = 3'h0;
         2'h1:    pre_last = 3'h1;
         2'h2:    pre_last = 3'h3;
         default: pre_last = 3'h7;
      endcase
   end

   // one output tick per 1, 2, 4 or 8 source ticks
   // divide by one on the system clock leaves pwm_tick high on every cycle,
   // so downstream logic must treat it as a plain enable, not an edge; the
   // count holds while no source tick arrives, so a source switch keeps
   // the phase reached so far
   always_comb begin
      pre_cnt_nxt = pre_cnt_r;
      tick_nxt    = 1'b0;
      if (src_tick) begin
         if (pre_cnt_r >= pre_last) begin
            pre_cnt_nxt = 3'h0;
            tick_nxt    = 1'b1;
         end else begin
            pre_cnt_nxt = pre_cnt_r + 3'h1;
         end
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         ext_prev_r <= 1'b0;
         pre_cnt_r  <= 3'h0;
         pwm_tick   <= 1'b0;
      end else begin
         ext_prev_r <= ext_prev_nxt;
         pre_cnt_r  <= pre_cnt_nxt;
         pwm_tick   <= tick_nxt;
      end
   end

   // ----------------------------------------
   // polarity, mode and dead time per pair
   // ----------------------------------------
   // pair k drives channels 2k (high side) and 2k+1 (low side)
   // in independent mode the same pair modules pass both requests straight
   // through, so the mode can change without a second output path
   logic [CHANNELS-1:0] shaped;
   logic [CHANNELS-1:0] out_nxt;

   genvar k;
   generate
      for (k = 0; k < PAIRS; k++) begin : g_pair
         pwmrpd_dt_if dt ();
         assign dt.raw_high   = raw_channel[2*k];
         assign dt.complement = !ctl1_r[`PWMRPD_INDEP];
         assign dt.dead_count = db_r;
         pwmrpd_dead_pair u_pair (
            .clock   (clock),
            .rst_b   (rst_b),
            .raw_low (raw_channel[2*k+1]),
            .dt      (dt)
         );
         // pairs 1/0, 2/3, 4/5 take polarity bits 2, 3, 4
         // polarity acts after the dead-time shaping, so during dead time an
         // inverted pair rests high: each gate driver still sees its own
         // inactive level and shoot-through cannot be created here
         assign shaped[2*k]   = dt.out_high ^ ctl1_r[`PWMRPD_POL_PAIR10+k];
         assign shaped[2*k+1] = dt.out_low  ^ ctl1_r[`PWMRPD_POL_PAIR10+k];
      end
   endgenerate

   logic                reload_event_nxt;
   logic [1:0]          active_divider_nxt;
   logic                unit_enable_nxt;

   // every top-level output is a flop, so the power stage never sees a
   // glitch from the decode and shaping logic; these are its next values
   always_comb begin
      out_nxt            = shaped;
      reload_event_nxt   = reload_r;
      active_divider_nxt = div_act_r;
      unit_enable_nxt    = ctl0_r[`PWMRPD_ENABLE];
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         pwm_out        <= '0;
         reload_event   <= 1'b0;
         active_divider <= 2'h0;
         unit_enable    <= 1'b0;
      end else begin
         pwm_out        <= out_nxt;
         reload_event   <= reload_event_nxt;
         active_divider <= active_divider_nxt;
         unit_enable    <= unit_enable_nxt;
      end
   end
endmodule : pwmrpd_top
`default_nettype wire

// >>> bench/pwmrpd_checker.sv
// Purpose: port-level assertions for pwmrpd_top
// Assumes: one clock, asynchronous active-low reset
// Notes:   attached by bind at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module pwmrpd_checker (
   input wire logic        clock,
   input wire logic        rst_b,
   input wire logic [11:0] addr,
   input wire logic        wr_stb,
   input wire logic        rd_stb,
   input wire logic [7:0]  rdata,
   input wire logic        ext_clock_select,
   input wire logic        ext_pwm_clock,
   input wire logic        period_end,
   input wire logic        pwm_tick,
   input wire logic        reload_event,
   input wire logic [1:0]  active_divider,
   input wire logic        unit_enable
);
   // ------
   // start-up guard
   // ------
   // outputs sit at zero for the first edges, so full-rate ticks are not due yet
   logic [1:0] run_r;
   logic [1:0] run_nxt;
   always_comb run_nxt = (run_r == 2'h3) ? run_r : run_r + 2'h1;
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) run_r <= 2'h0;
      else run_r <= run_nxt;
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_b);
   // read answer and refusals
   a_rdata_idle_zero: assert property (!$past(rd_stb) |-> rdata == 8'h00)
      else $error("read data not zero outside the answer cycle");
   a_unmapped_zero: assert property (
      $past(rd_stb) && !($past(addr) inside {[12'hF20:12'hF22]}) |-> rdata == 8'h00)
      else $error("unmapped read returned nonzero");
   a_enable_from_write: assert property (
      !$stable(unit_enable) |-> $past(wr_stb && addr == 12'hF20)
      || $past(wr_stb && addr == 12'hF20, 2)) else $error("enable moved without a write");
   // reload timing
   a_reload_after_period: assert property (reload_event |-> $past(period_end, 2))
      else $error("reload event without period end two cycles before");
   a_divider_at_reload: assert property (!$stable(active_divider) |-> reload_event)
      else $error("divider changed outside a reload event");
   // prescaler
   a_tick_full_rate: assert property (
      run_r == 2'h3 && active_divider == 2'h0 && $past(active_divider) == 2'h0
      && !ext_clock_select && !$past(ext_clock_select) |-> pwm_tick)
      else $error("divide by one did not tick every cycle");
   a_tick_spaced: assert property (
      pwm_tick && active_divider != 2'h0 && $past(active_divider, 2) == active_divider
      |=> !pwm_tick) else $error("divided tick on two cycles in a row");
   a_ext_quiet: assert property (
      (ext_clock_select && $stable(ext_pwm_clock)) [*6] |-> !pwm_tick)
      else $error("tick without an external clock edge");
endmodule : pwmrpd_checker
bind pwmrpd_top pwmrpd_checker u_pwmrpd_checker (.clock(clock), .rst_b(rst_b), .addr(addr),
   .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .ext_clock_select(ext_clock_select),
   .ext_pwm_clock(ext_pwm_clock), .period_end(period_end), .pwm_tick(pwm_tick),
   .reload_event(reload_event), .active_divider(active_divider), .unit_enable(unit_enable));
`default_nettype wire

// >>> bench/pwmrpd_gate_model.sv
// Purpose: power-stage gate drivers, counting cycles with shoot-through on any leg
// Assumes: invert mirrors the polarity bits last written
// Notes:   pair_mode low while outputs run as separate channels
`timescale 1ns/1ps
`default_nettype none
module pwmrpd_gate_model (
   input  wire logic       clock,
   input  wire logic [5:0] pwm_out,
   input  wire logic [2:0] invert,
   input  wire logic       pair_mode,
   output wire logic [7:0] shoot_count
);
   logic [5:0] on_level;
   logic [7:0] shoot_r = 8'h00;
   // a gate conducts at its active level; polarity flips that level per pair
   assign on_level = pwm_out ^ {{2{invert[2]}}, {2{invert[1]}}, {2{invert[0]}}};
   assign shoot_count = shoot_r;
   // both switches of one leg on together shorts the supply
   always @(posedge clock) begin
      for (int k = 0; k < 3; k++) begin
         if (pair_mode && on_level[2*k] && on_level[2*k+1]) begin
            shoot_r <= shoot_r + 8'h01;
         end
      end
   end
endmodule : pwmrpd_gate_model
`default_nettype wire

// >>> bench/tb.sv
// Purpose: register-driven tests of reload, prescale, polarity and dead time
// Assumes: pwm_out is shaped while the unit is disabled as well
// Notes:   counts of ticks and reloads are taken over whole divider cycles
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic        clock;
   logic        rst_b;
   logic [11:0] addr;
   logic [7:0]  wdata;
   logic        wr_stb;
   logic        rd_stb;
   logic [7:0]  rdata;
   logic        ext_clock_select;
   logic        ext_pwm_clock;
   logic        period_end;
   logic [5:0]  raw_channel;
   logic        pwm_tick;
   logic        reload_event;
   logic [1:0]  active_divider;
   logic        unit_enable;
   logic [5:0]  pwm_out;
   logic [2:0]  invert = 3'h0;
   logic        pair_mode = 1'b1;
   logic [7:0]  shoot_count;
   int          miscompares = 0;
   int          compares = 0;
   int          n_rel = 0;
   int          n_tick = 0;
   int          cyc = 0;
   pwmrpd_top #(.CHANNELS(6)) u_pwmrpd_top (.clock(clock), .rst_b(rst_b), .addr(addr),
      .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
      .ext_clock_select(ext_clock_select), .ext_pwm_clock(ext_pwm_clock),
      .period_end(period_end), .raw_channel(raw_channel), .pwm_tick(pwm_tick),
      .reload_event(reload_event), .active_divider(active_divider),
      .unit_enable(unit_enable), .pwm_out(pwm_out));
   pwmrpd_gate_model u_pwmrpd_gate_model (.clock(clock), .pwm_out(pwm_out),
      .invert(invert), .pair_mode(pair_mode), .shoot_count(shoot_count));
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   // ------
   // bus and check tasks
   // ------
   task automatic test_done;
      if (miscompares == 0 && compares > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : test_done
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge clock);
      wr_stb <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clock);
      wr_stb <= 1'b0;
   endtask : wr
   // read data is looked at only in the single cycle after the strobe
   task automatic rd(input logic [11:0] a, input logic [7:0] exp);
      @(posedge clock);
      rd_stb <= 1'b1;
      addr <= a;
      @(posedge clock);
      rd_stb <= 1'b0;
      #1;
      chk("rdata", exp, rdata);
   endtask : rd
   task automatic pulse;
      @(posedge clock);
      period_end <= 1'b1;
      @(posedge clock);
      period_end <= 1'b0;
      repeat (3) @(posedge clock);
      #1;
   endtask : pulse
   // counts cycles with pair zero fully off until the wanted side shows
   task automatic dead(input logic [7:0] d, input logic [1:0] want);
      int z;
      z = 0;
      for (int i = 0; i < 300 && pwm_out[1:0] !== want; i++) begin
         @(posedge clock);
         #1;
         if (pwm_out[1:0] === 2'b00) z++;
      end
      chk("pair zero", {6'h00, want}, {6'h00, pwm_out[1:0]});
      chk("dead cycles", d, z[7:0]);
   endtask : dead
   // event counters and the hang limit
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (reload_event === 1'b1) n_rel <= n_rel + 1;
      if (pwm_tick === 1'b1) n_tick <= n_tick + 1;
      if (cyc == 4000) begin
         miscompares++;
         test_done();
      end
   end
   // ------
   // main sequence
   // ------
   initial begin
      rst_b = 1'b0;
      addr = 12'h000;
      wdata = 8'h00;
      wr_stb = 1'b0;
      rd_stb = 1'b0;
      ext_clock_select = 1'b0;
      ext_pwm_clock = 1'b0;
      period_end = 1'b0;
      raw_channel = 6'h00;
      repeat (5) @(posedge clock);
      rst_b <= 1'b1;
      rd(12'hF20, 8'h00);
      rd(12'hF21, 8'h00);
      rd(12'hF22, 8'h01);
      wr(12'hF23, 8'h5A);
      rd(12'hF23, 8'h00);
      chk("pwm_out", 8'h2A, {2'b00, pwm_out});
      wr(12'hF22, 8'h03);
      rd(12'hF22, 8'h03);
      @(posedge clock);
      raw_channel <= 6'h01;
      dead(8'h03, 2'b01);
      wr(12'hF22, 8'h01);
      @(posedge clock);
      raw_channel <= 6'h00;
      dead(8'h01, 2'b10);
      // each polarity bit flips its own pair and no other
      for (int k = 0; k < 3; k++) begin
         wr(12'hF21, 8'h04 << k);
         invert <= 3'h1 << k;
         repeat (4) @(posedge clock);
         #1;
         chk("pwm_out", 8'h2A ^ (8'h03 << (2 * k)), {2'b00, pwm_out});
      end
      pair_mode <= 1'b0;
      invert <= 3'h0;
      wr(12'hF21, 8'h20);
      @(posedge clock);
      raw_channel <= 6'h15;
      repeat (4) @(posedge clock);
      #1;
      chk("pwm_out", 8'h15, {2'b00, pwm_out});
      // enabled unit refuses dead time and mode changes
      wr(12'hF20, 8'h01);
      wr(12'hF22, 8'h07);
      rd(12'hF22, 8'h01);
      chk("unit_enable", 8'h01, {7'h00, unit_enable});
      wr(12'hF21, 8'h00);
      rd(12'hF21, 8'h20);
      chk("pwm_out", 8'h15, {2'b00, pwm_out});
      // every reload code over eight whole periods
      for (int c = 0; c < 4; c++) begin
         wr(12'hF21, {c[1:0], 6'h20});
         rd(12'hF21, {c[1:0], 6'h20});
         pulse();
         n_rel = 0;
         repeat (8) pulse();
         chk("reloads", 8'h08 >> c, n_rel[7:0]);
      end
      wr(12'hF21, 8'h22);
      repeat (2) pulse();
      chk("divider", 8'h00, {6'h00, active_divider});
      rd(12'hF21, 8'h22);
      wr(12'hF20, 8'h03);
      chk("divider", 8'h00, {6'h00, active_divider});
      pulse();
      chk("divider", 8'h02, {6'h00, active_divider});
      rd(12'hF20, 8'h01);
      n_tick = 0;
      repeat (32) @(posedge clock);
      #1;
      chk("ticks", 8'h08, n_tick[7:0]);
      // every divider code through the ready handshake, ending on divide by 4
      for (int j = 0; j < 4; j++) begin
         wr(12'hF21, {6'h08, j[1:0] + 2'h3});
         wr(12'hF20, 8'h03);
         pulse();
         chk("divider", {6'h00, j[1:0] + 2'h3}, {6'h00, active_divider});
         repeat (8) @(posedge clock);
         #1;
         n_tick = 0;
         repeat (32) @(posedge clock);
         #1;
         chk("ticks", 8'h20 >> (j[1:0] + 2'h3), n_tick[7:0]);
      end
      // divider on an external source: sixteen rising edges
      @(posedge clock);
      ext_clock_select <= 1'b1;
      repeat (8) @(posedge clock);
      #1;
      n_tick = 0;
      repeat (32) begin
         repeat (3) @(posedge clock);
         ext_pwm_clock <= ~ext_pwm_clock;
      end
      repeat (10) @(posedge clock);
      #1;
      chk("ticks", 8'h04, n_tick[7:0]);
      chk("shoot", 8'h00, shoot_count);
      test_done();
   end
endmodule : tb
`default_nettype wire
